// File: dv/hsc_cmd_decoder_chk.sv
// Port checker for the command decoder, bound into every decoder instance.
// Assumes one clock, a synchronous active-low reset and clk_en_in held high.
`timescale 1ns/10ps
module hsc_cmd_decoder_chk (
  input wire logic                   clock_in,
  input wire logic                   rstn_in,
  input wire logic                   clk_en_in,
  input wire logic                   wb_cyc_in,
  input wire logic                   wb_stb_in,
  input wire logic                   wb_we_in,
  input wire logic [7:0]             wb_adr_in,
  input wire logic [3:0]             wb_sel_in,
  input wire logic [31:0]            wb_dat_in,
  input wire logic                   wb_ack_out,
  input wire hsc_cmd_pkg::settings_t settings_out,
  input wire logic [7:0]             module_status_byte_out,
  input wire logic                   powerup_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  logic               take;
  logic               cmd;
  logic [7:0]         code;
  logic signed [24:0] span;
  // A request is taken when strobed with no answer pending; commands need all lanes.
  assign take = wb_cyc_in && wb_stb_in && !wb_ack_out && clk_en_in;
  assign cmd  = take && wb_we_in && wb_adr_in == hsc_cmd_pkg::REG_COMMAND && wb_sel_in == 4'hF;
  assign code = wb_dat_in[7:0];
  assign span = $signed({settings_out.upper[23], settings_out.upper})
              - $signed({settings_out.lower[23], settings_out.lower});
  // Each property ties an output to the request or state that causes it.
  chk_ack_answer: assert property (take |=> wb_ack_out)
    else $error("request not answered in one cycle");
  chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
  chk_reset_values: assert property (disable iff (1'b0) !rstn_in |=>
    powerup_out && settings_out.accum == 24'h00_0000 && settings_out.upper == 24'h7F_FFFF
    && settings_out.lower == 24'h00_0000) else $error("settings wrong after reset");
  chk_span_floor: assert property (span >= 25'sh000_0080)
    else $error("count limits closer than 128");
  chk_accum_cause: assert property ($changed(settings_out.accum) |->
    $past(cmd && (code == 8'h01 || code == 8'h20 && !powerup_out)))
    else $error("accumulate changed without a load");
  chk_powerup_hold: assert property (cmd && powerup_out && code != 8'h01 && code != 8'h06
    |=> $stable(settings_out) && powerup_out) else $error("command obeyed under power-up");
  chk_powerup_clear: assert property (cmd && code == 8'h06 |=> !powerup_out)
    else $error("power-up flag not cleared");
  chk_card_reset: assert property (cmd && code == 8'h01 |=> powerup_out
    && module_status_byte_out[7:5] == 3'b000 && settings_out.upper == 24'h7F_FFFF)
    else $error("card reset not applied");
  chk_timebase_err: assert property (cmd && !powerup_out && code == 8'h24
    && (wb_dat_in[31:8] == 24'h00_0000 || wb_dat_in[31:24] != 8'h00)
    |=> module_status_byte_out[7:5] == 3'b100 && $stable(settings_out.timebase))
    else $error("bad time base not refused");
  chk_return_type: assert property (cmd && !powerup_out
    && (code inside {[8'h30:8'h3B], [8'h40:8'h44]}) |=> module_status_byte_out[7:5] == 3'b011)
    else $error("return type not shown");
endmodule

bind hsc_cmd_decoder hsc_cmd_decoder_chk i_chk (
  .clock_in(clock_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
  .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out), .settings_out(settings_out),
  .module_status_byte_out(module_status_byte_out), .powerup_out(powerup_out));

// File: dv/hsc_host_model.sv
// Host model: a classic Wishbone master standing for the controller CPU.
// Assumes the decoder answers within a few cycles; a missing answer returns ok low.
`timescale 1ns/10ps
module hsc_host_model (
  input  wire logic        clock_in,
  input  wire logic        wb_ack_in,
  input  wire logic [31:0] wb_dat_in,
  output logic             wb_cyc_out,
  output logic             wb_stb_out,
  output logic             wb_we_out,
  output logic [7:0]       wb_adr_out,
  output logic [3:0]       wb_sel_out,
  output logic [31:0]      wb_dat_out
);
  // The bus is idle and fully defined from time zero.
  initial begin
    {wb_cyc_out, wb_stb_out, wb_we_out} = 3'h0;
    {wb_adr_out, wb_sel_out, wb_dat_out} = 44'h0;
  end
  // One cycle held until ack; released qualifiers are inverted so they never look stale.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] x, output logic [31:0] r, output logic ok);
    int n;
    n = 0;
    repeat ($urandom_range(1, 0)) @(posedge clock_in);
    @(posedge clock_in);
    {wb_cyc_out, wb_stb_out, wb_we_out} <= {2'b11, w};
    {wb_adr_out, wb_sel_out, wb_dat_out} <= {a, s, x};
    do begin
      @(posedge clock_in);
      n++;
    end while (wb_ack_in !== 1'b1 && n < 32);
    r = wb_dat_in;
    ok = wb_ack_in;
    {wb_cyc_out, wb_stb_out, wb_we_out} <= {2'b00, ~w};
    {wb_adr_out, wb_sel_out, wb_dat_out} <= ~{a, s, x};
  endtask
endmodule

// File: dv/testbench.sv
// Self-checking bench: a host model sends commands and the bench predicts each answer.
// Assumes the checker is bound to the decoder and clk_en_in stays high.
`timescale 1ns/10ps
module testbench;
  logic                   clock_in, rstn_in, cyc, stb, we, ack, ok, powerup;
  logic [7:0]             adr, c, e;
  logic [3:0]             sel;
  logic [31:0]            wdat, rdat, rd;
  logic [23:0]            m_acc, m_up, m_lo, m_sen, m_tb, d;
  logic [23:0]            m_pre [12];
  hsc_cmd_pkg::settings_t set, snap;
  int                     failures, compares;
  logic [31:0]            corner [17] = '{32'h2280_0000, 32'h2180_007F, 32'h2180_0080,
    32'h2280_0001, 32'h217F_FFFF, 32'h227F_FF80, 32'h227F_FF7F, 32'h2200_0000, 32'h20FF_FFFF,
    32'h207F_FFFF, 32'h2100_1000, 32'h2000_1001, 32'h2000_1000, 32'h2400_0000, 32'h2401_0000,
    32'h2400_0001, 32'h2400_FFFF};

  hsc_cmd_decoder i_dut (.clock_in(clock_in), .rstn_in(rstn_in), .clk_en_in(1'b1),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .settings_out(set),
    .module_status_byte_out(), .powerup_out(powerup));
  hsc_host_model i_host (.clock_in(clock_in), .wb_ack_in(ack), .wb_dat_in(rdat),
    .wb_cyc_out(cyc), .wb_stb_out(stb), .wb_we_out(we), .wb_adr_out(adr),
    .wb_sel_out(sel), .wb_dat_out(wdat));

  // Free-running 250 MHz clock.
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  // Counts a comparison and reports a mismatch.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One bus cycle through the host; a missing answer ends the run.
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] x);
    i_host.xfer(w, a, s, x, rd, ok);
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED bus ack expected 1 seen %b", ok);
      end_of_test();
    end
  endtask

  // Sends one command word, then reads the returned word.
  task automatic cmd(input logic [7:0] k, input logic [23:0] x);
    bus(1'b1, hsc_cmd_pkg::REG_COMMAND, 4'hF, {x, k});
    bus(1'b0, hsc_cmd_pkg::REG_RETURN, 4'hF, 32'h0);
  endtask

  // Compares the returned type field and data bytes.
  task automatic ret(input logic [2:0] t, input logic [23:0] x);
    check("return type", 32'(rd[7:5]), 32'(t));
    check("return data", 32'(rd[31:8]), 32'(x));
  endtask

  // Puts the predicted settings back to their power-up values.
  task automatic init_model();
    {m_acc, m_lo, m_sen} = 72'h0;
    m_up = 24'h7F_FFFF;
    m_tb = 24'(hsc_cmd_pkg::TIMEBASE_RESET);
    foreach (m_pre[i]) m_pre[i] = 24'h00_0000;
  endtask

  // Compares the stored settings, and preset k[3:0], with the prediction.
  task automatic same(input logic [7:0] k);
    check("accum", 32'(set.accum), 32'(m_acc));
    check("upper", 32'(set.upper), 32'(m_up));
    check("lower", 32'(set.lower), 32'(m_lo));
    check("sense", 32'(set.sense), 32'(m_sen));
    check("time base", 32'(set.timebase), 32'(m_tb));
    check("preset", 32'(set.preset[k[3:0]]), 32'(m_pre[k[3:0]]));
  endtask

  // Error code a load should give against the predicted limits, zero if accepted.
  function automatic logic [7:0] judge(input logic [7:0] k, input logic [23:0] x);
    if (k inside {[8'h10:8'h1B], 8'h20})
      return ($signed(x) > $signed(m_up) || $signed(x) < $signed(m_lo)) ? 8'h02 : 8'h00;
    if (k == 8'h21)
      return ($signed({x[23], x}) - $signed({m_lo[23], m_lo}) < 128) ? 8'h03 : 8'h00;
    if (k == 8'h22)
      return ($signed({m_up[23], m_up}) - $signed({x[23], x}) < 128) ? 8'h03 : 8'h00;
    if (k == 8'h24)
      return (x == 24'h00_0000 || x > 24'h00_FFFF) ? 8'h04 : 8'h00;
    return 8'h00;
  endfunction

  // Value that a return command should bring back.
  function automatic logic [23:0] expect_ret(input logic [7:0] k);
    if (k <= 8'h3B) return m_pre[k[3:0]];
    case (k)
      8'h40: return m_acc;
      8'h41: return m_up;
      8'h42: return m_lo;
      8'h43: return m_sen;
      default: return m_tb;
    endcase
  endfunction

  // Loads one setting, predicts the verdict and compares the outcome.
  task automatic load(input logic [7:0] k, input logic [23:0] x);
    e = judge(k, x);
    cmd(k, x);
    if (e != 8'h00) begin
      ret(3'b100, {16'h0000, e});
    end else if (k < 8'h20) begin
      m_pre[k[3:0]] = x;
    end else begin
      case (k)
        8'h20: m_acc = x;
        8'h21: m_up = x;
        8'h22: m_lo = x;
        8'h23: m_sen = x;
        default: m_tb = x;
      endcase
    end
    same(k);
  endtask

  // Main sequence: reset, lockout, corners, random loads, returns, reserved codes.
  initial begin
    rstn_in = 1'b0;
    failures = 0;
    compares = 0;
    init_model();
    void'($urandom(40107));
    repeat (8) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    same(8'h10);
    cmd(8'h20, 24'h00_0055);
    ret(3'b000, 24'h00_0000);
    same(8'h10);
    cmd(hsc_cmd_pkg::CMD_CLEAR_POWERUP, 24'h00_0000);
    check("power-up", 32'(powerup), 32'h0);
    bus(1'b1, hsc_cmd_pkg::REG_COMMAND, 4'h7, 32'h0000_3320);
    bus(1'b1, 8'h0C, 4'hF, 32'h0000_3320);
    bus(1'b0, 8'h08, 4'hF, 32'h0);
    check("unmapped read", rd, 32'h0);
    same(8'h10);
    foreach (corner[i]) load(corner[i][31:24], corner[i][23:0]);
    for (int i = 0; i < 80; i++) begin
      c = 8'($urandom_range(36, 16));
      if (c inside {[8'h1C:8'h1F]}) c = 8'h20;
      case ($urandom_range(3, 0))
        0: d = 24'($urandom);
        1: d = m_lo + 24'($urandom_range(129, 126));
        2: d = m_up - 24'($urandom_range(129, 126));
        default: d = 24'($urandom_range(2, 0));
      endcase
      load(c, d);
    end
    for (int r = 48; r <= 68; r++) begin
      if (r < 60 || r > 63) begin
        cmd(8'(r), 24'h00_0000);
        ret(3'b011, expect_ret(8'(r)));
      end
    end
    bus(1'b0, hsc_cmd_pkg::REG_RETURN, 4'hF, 32'h0);
    ret(3'b011, m_tb);
    for (int r = 28; r < 256; r++) begin
      if (r < 32 || r inside {[37:47], [60:63]} || r > 68) begin
        snap = set;
        cmd(8'(r), 24'($urandom));
        ret(3'b100, 24'h00_0001);
        check("settings kept", 32'(set !== snap), 32'h0);
      end
    end
    cmd(hsc_cmd_pkg::CMD_RESET_CARD, 24'h00_0000);
    init_model();
    ret(3'b000, 24'h00_0000);
    same(8'h10);
    cmd(8'h25, 24'h00_0000);
    ret(3'b000, 24'h00_0000);
    check("power-up", 32'(powerup), 32'h1);
    end_of_test();
  end
endmodule

// File: rtl/hsc_cmd_decoder.sv
// Command decoder of a high-speed counter card: setup loads and data returns.
// Assumes a classic Wishbone master on clock_in and a counting datapath that
// takes its settings from settings_out.
`timescale 1ns/10ps
module hsc_cmd_decoder (
  input  wire logic                   clock_in,
  input  wire logic                   rstn_in,
  input  wire logic                   clk_en_in,
  input  wire logic                   wb_cyc_in,
  input  wire logic                   wb_stb_in,
  input  wire logic                   wb_we_in,
  input  wire logic [7:0]             wb_adr_in,
  input  wire logic [3:0]             wb_sel_in,
  input  wire logic [31:0]            wb_dat_in,
  output logic      [31:0]            wb_dat_out,
  output logic                        wb_ack_out,
  output hsc_cmd_pkg::settings_t      settings_out,
  output logic      [7:0]             module_status_byte_out,
  output logic                        powerup_out
);

  // Whole state of the decoder in one record.
  typedef struct packed {
    hsc_cmd_pkg::settings_t  cfg;
    logic                    powerup;
    logic                    heartbeat;
    logic                    err_active;
    logic [7:0]              err_code;
    logic [2:0]              ret_type;
    hsc_cmd_pkg::ret_src_t   ret_src;
    logic [3:0]              ret_idx;
    logic                    ack;
    logic [31:0]             rdata;
    logic [7:0]              status;
  } state_t;

  state_t                     st;
  state_t                     next_st;
  hsc_cmd_pkg::check_t        verdict;
  hsc_cmd_pkg::return_word_t  ret_word;
  logic [7:0]                 command_code_byte;
  logic [23:0]                cmd_data;
  logic                       cmd_write;

  // Settings after power-up or a card reset.
  function automatic hsc_cmd_pkg::settings_t default_settings();
    hsc_cmd_pkg::settings_t s;
    for (int i = 0; i < hsc_cmd_pkg::NUM_PRESETS; i++) begin
      s.preset[i] = hsc_cmd_pkg::PRESET_RESET;
    end
    s.accum    = hsc_cmd_pkg::ACCUM_RESET;
    s.upper    = hsc_cmd_pkg::UPPER_RESET;
    s.lower    = hsc_cmd_pkg::LOWER_RESET;
    s.sense    = hsc_cmd_pkg::SENSE_RESET;
    s.timebase = hsc_cmd_pkg::TIMEBASE_RESET;
    return s;
  endfunction

  // Status byte of a state: heartbeat, power-up flag and the returned type.
  function automatic logic [7:0] status_of(input state_t s);
    status_of                                = 8'h00;
    status_of[hsc_cmd_pkg::SB_HEARTBEAT]     = s.heartbeat;
    status_of[hsc_cmd_pkg::SB_POWERUP]       = s.powerup;
    status_of[hsc_cmd_pkg::SB_TYPE_LSB +: 3] =
      s.err_active ? hsc_cmd_pkg::RTYPE_ERROR : s.ret_type;
  endfunction

  // Whole reset value of the state record.
  function automatic state_t reset_state();
    state_t r;
    r.cfg        = default_settings();
    r.powerup    = 1'b1;
    r.heartbeat  = 1'b0;
    r.err_active = 1'b0;
    r.err_code   = hsc_cmd_pkg::ERR_NONE;
    r.ret_type   = hsc_cmd_pkg::RTYPE_ACCUM;
    r.ret_src    = hsc_cmd_pkg::SRC_ACCUM;
    r.ret_idx    = 4'h0;
    r.ack        = 1'b0;
    r.rdata      = 32'h0000_0000;
    r.status     = status_of(r);
    return r;
  endfunction

  // The command word splits into the code byte and three data bytes.
  assign command_code_byte = wb_dat_in[7:0];
  assign cmd_data          = wb_dat_in[31:8];
  assign cmd_write         = wb_cyc_in && wb_stb_in && !st.ack && wb_we_in &&
                             (wb_adr_in == hsc_cmd_pkg::REG_COMMAND) &&
                             (wb_sel_in == 4'hF);

  // Range and span checks against the limits that hold right now.
  hsc_load_checker u_checker (
    .code_in     (command_code_byte),
    .data_in     (cmd_data),
    .upper_in    (st.cfg.upper),
    .lower_in    (st.cfg.lower),
    .verdict_out (verdict)
  );

  // Builds the returned word from the live state and the held selection.
  always_comb begin
    ret_word.status = st.status;
    if (st.err_active) begin
      ret_word.data = {16'h0000, st.err_code};
    end else begin
      case (st.ret_src)
        hsc_cmd_pkg::SRC_ACCUM:    ret_word.data = st.cfg.accum;
        hsc_cmd_pkg::SRC_PRESET:   ret_word.data = st.cfg.preset[st.ret_idx];
        hsc_cmd_pkg::SRC_UPPER:    ret_word.data = st.cfg.upper;
        hsc_cmd_pkg::SRC_LOWER:    ret_word.data = st.cfg.lower;
        hsc_cmd_pkg::SRC_SENSE:    ret_word.data = st.cfg.sense;
        hsc_cmd_pkg::SRC_TIMEBASE: ret_word.data = {8'h00, st.cfg.timebase};
        default:                   ret_word.data = st.cfg.accum;
      endcase
    end
  end

  // Bus handshake and command execution; one accepted command is one scan.
  always_comb begin
    next_st     = st;
    next_st.ack = 1'b0;
    if (wb_cyc_in && wb_stb_in && !st.ack) begin
      // Every request is answered, unmapped offsets read zero.
      next_st.ack = 1'b1;
      if (!wb_we_in && wb_adr_in == hsc_cmd_pkg::REG_RETURN) begin
        next_st.rdata = ret_word;
      end else begin
        next_st.rdata = 32'h0000_0000;
      end
    end
    if (cmd_write) begin
      next_st.heartbeat = ~st.heartbeat;
      if (command_code_byte == hsc_cmd_pkg::CMD_RESET_CARD) begin
        // Card reset restores every default and raises the power-up flag.
        next_st.cfg        = default_settings();
        next_st.powerup    = 1'b1;
        next_st.err_active = 1'b0;
        next_st.err_code   = hsc_cmd_pkg::ERR_NONE;
        next_st.ret_type   = hsc_cmd_pkg::RTYPE_ACCUM;
        next_st.ret_src    = hsc_cmd_pkg::SRC_ACCUM;
        next_st.ret_idx    = 4'h0;
      end else if (command_code_byte == hsc_cmd_pkg::CMD_CLEAR_POWERUP) begin
        next_st.powerup    = 1'b0;
        next_st.err_active = 1'b0;
      end else if (st.powerup) begin
        // Everything else is ignored until the flag is cleared.
        next_st.powerup = 1'b1;
      end else if (!verdict.accept) begin
        // A refused command leaves all settings as they were.
        next_st.err_active = 1'b1;
        next_st.err_code   = verdict.err_code;
      end else begin
        next_st.err_active = 1'b0;
        if (command_code_byte >= hsc_cmd_pkg::CMD_LOAD_PRESET_LO &&
            command_code_byte <= hsc_cmd_pkg::CMD_LOAD_PRESET_HI) begin
          next_st.cfg.preset[4'(command_code_byte - hsc_cmd_pkg::CMD_LOAD_PRESET_LO)] =
            cmd_data;
        end else if (command_code_byte >= hsc_cmd_pkg::CMD_RET_PRESET_LO &&
                     command_code_byte <= hsc_cmd_pkg::CMD_RET_PRESET_HI) begin
          next_st.ret_type = hsc_cmd_pkg::RTYPE_REG;
          next_st.ret_src  = hsc_cmd_pkg::SRC_PRESET;
          next_st.ret_idx  = 4'(command_code_byte - hsc_cmd_pkg::CMD_RET_PRESET_LO);
        end else begin
          case (command_code_byte)
            hsc_cmd_pkg::CMD_LOAD_ACCUM:    next_st.cfg.accum    = cmd_data;
            hsc_cmd_pkg::CMD_LOAD_UPPER:    next_st.cfg.upper    = cmd_data;
            hsc_cmd_pkg::CMD_LOAD_LOWER:    next_st.cfg.lower    = cmd_data;
            hsc_cmd_pkg::CMD_LOAD_SENSE:    next_st.cfg.sense    = cmd_data;
            hsc_cmd_pkg::CMD_LOAD_TIMEBASE: next_st.cfg.timebase = cmd_data[15:0];
            hsc_cmd_pkg::CMD_RET_ACCUM: begin
              next_st.ret_type = hsc_cmd_pkg::RTYPE_REG;
              next_st.ret_src  = hsc_cmd_pkg::SRC_ACCUM;
            end
            hsc_cmd_pkg::CMD_RET_UPPER: begin
              next_st.ret_type = hsc_cmd_pkg::RTYPE_REG;
              next_st.ret_src  = hsc_cmd_pkg::SRC_UPPER;
            end
            hsc_cmd_pkg::CMD_RET_LOWER: begin
              next_st.ret_type = hsc_cmd_pkg::RTYPE_REG;
              next_st.ret_src  = hsc_cmd_pkg::SRC_LOWER;
            end
            hsc_cmd_pkg::CMD_RET_SENSE: begin
              next_st.ret_type = hsc_cmd_pkg::RTYPE_REG;
              next_st.ret_src  = hsc_cmd_pkg::SRC_SENSE;
            end
            hsc_cmd_pkg::CMD_RET_TIMEBASE: begin
              next_st.ret_type = hsc_cmd_pkg::RTYPE_REG;
              next_st.ret_src  = hsc_cmd_pkg::SRC_TIMEBASE;
            end
            default: begin
              // Lower commands belong to other logic; here they clear the error flag and store nothing.
              next_st.ret_type = st.ret_type;
            end
          endcase
        end
      end
    end
    // The status byte is registered so that its pin is a plain flop output.
    next_st.status = status_of(next_st);
  end

  // State register; a low clock enable freezes everything except a reset.
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      st <= reset_state();
    end else if (clk_en_in) begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register.
  assign wb_ack_out             = st.ack;
  assign wb_dat_out             = st.rdata;
  assign settings_out           = st.cfg;
  assign powerup_out            = st.powerup;
  assign module_status_byte_out = st.status;

endmodule

// File: rtl/hsc_cmd_pkg.sv
// Shared constants and carrier types for the counter setup command decoder.
// Assumes one 250 MHz clock domain and a classic Wishbone register port.
package hsc_cmd_pkg;

  // Width of one command or returned data value, carried in two's complement.
  localparam int DATA_W = 24;
  localparam int NUM_PRESETS = 12;
  localparam int PRESET_IDX_W = 4;

  // Clock period in nanoseconds, kept for any derived timing.
  localparam int CLOCK_PERIOD_NS = 4;

  // Wishbone register byte offsets.
  localparam logic [7:0] REG_COMMAND = 8'h00;
  localparam logic [7:0] REG_RETURN  = 8'h04;

  // Command numbers handled by this block.
  localparam logic [7:0] CMD_RESET_CARD      = 8'h01;
  localparam logic [7:0] CMD_CLEAR_POWERUP   = 8'h06;
  localparam logic [7:0] CMD_OTHER_LAST      = 8'h06;
  localparam logic [7:0] CMD_LOAD_PRESET_LO  = 8'h10;
  localparam logic [7:0] CMD_LOAD_PRESET_HI  = 8'h1B;
  localparam logic [7:0] CMD_LOAD_ACCUM      = 8'h20;
  localparam logic [7:0] CMD_LOAD_UPPER      = 8'h21;
  localparam logic [7:0] CMD_LOAD_LOWER      = 8'h22;
  localparam logic [7:0] CMD_LOAD_SENSE      = 8'h23;
  localparam logic [7:0] CMD_LOAD_TIMEBASE   = 8'h24;
  localparam logic [7:0] CMD_RET_PRESET_LO   = 8'h30;
  localparam logic [7:0] CMD_RET_PRESET_HI   = 8'h3B;
  localparam logic [7:0] CMD_RET_ACCUM       = 8'h40;
  localparam logic [7:0] CMD_RET_UPPER       = 8'h41;
  localparam logic [7:0] CMD_RET_LOWER       = 8'h42;
  localparam logic [7:0] CMD_RET_SENSE       = 8'h43;
  localparam logic [7:0] CMD_RET_TIMEBASE    = 8'h44;

  // Power-up values of the stored settings.
  localparam logic [23:0] ACCUM_RESET    = 24'h00_0000;
  localparam logic [23:0] UPPER_RESET    = 24'h7F_FFFF;
  localparam logic [23:0] LOWER_RESET    = 24'h00_0000;
  localparam logic [23:0] SENSE_RESET    = 24'h00_0000;
  localparam logic [23:0] PRESET_RESET   = 24'h00_0000;
  localparam logic [15:0] TIMEBASE_RESET = 16'h03E8;

  // Least span between the count limits, and the time base range in milliseconds.
  localparam logic [24:0] MIN_SPAN     = 25'h000_0080;
  localparam logic [23:0] TIMEBASE_MIN = 24'h00_0001;
  localparam logic [23:0] TIMEBASE_MAX = 24'h00_FFFF;

  // Status byte field positions, counted from bit 0.
  localparam int SB_HEARTBEAT = 0;
  localparam int SB_POWERUP   = 1;
  localparam int SB_TYPE_LSB  = 5;

  // Returned data type codes.
  localparam logic [2:0] RTYPE_ACCUM = 3'h0;
  localparam logic [2:0] RTYPE_REG   = 3'h3;
  localparam logic [2:0] RTYPE_ERROR = 3'h4;

  // Error codes returned in the low data byte.
  localparam logic [7:0] ERR_NONE     = 8'h00;
  localparam logic [7:0] ERR_RESERVED = 8'h01;
  localparam logic [7:0] ERR_LIMIT    = 8'h02;
  localparam logic [7:0] ERR_SPAN     = 8'h03;
  localparam logic [7:0] ERR_TIMEBASE = 8'h04;

  // Source of the returned data bytes.
  typedef enum logic [2:0] {
    SRC_ACCUM,
    SRC_PRESET,
    SRC_UPPER,
    SRC_LOWER,
    SRC_SENSE,
    SRC_TIMEBASE
  } ret_src_t;

  // Settings handed to the counting datapath.
  typedef struct packed {
    logic [NUM_PRESETS-1:0][DATA_W-1:0] preset;
    logic [DATA_W-1:0]                  accum;
    logic [DATA_W-1:0]                  upper;
    logic [DATA_W-1:0]                  lower;
    logic [DATA_W-1:0]                  sense;
    logic [15:0]                        timebase;
  } settings_t;

  // Verdict of the load checker on one command.
  typedef struct packed {
    logic       accept;
    logic [7:0] err_code;
  } check_t;

  // One returned word: three data bytes above the status byte.
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [7:0]        status;
  } return_word_t;

endpackage

// File: rtl/hsc_load_checker.sv
// Range checker that judges one command against the current count limits.
// Assumes purely combinational use inside the command decoder.
`timescale 1ns/10ps
module hsc_load_checker (
  input  wire logic [7:0]                code_in,
  input  wire logic [23:0]               data_in,
  input  wire logic [23:0]               upper_in,
  input  wire logic [23:0]               lower_in,
  output hsc_cmd_pkg::check_t            verdict_out
);

  // True when a signed value lies between the lower and upper limit.
  function automatic logic in_limits(input logic [23:0] v,
                                     input logic [23:0] up,
                                     input logic [23:0] lo);
    in_limits = ($signed(v) <= $signed(up)) && ($signed(v) >= $signed(lo));
  endfunction

  // True when the upper limit stands at least the least span above the lower.
  function automatic logic span_ok(input logic [23:0] up, input logic [23:0] lo);
    logic signed [24:0] diff;
    diff = $signed({up[23], up}) - $signed({lo[23], lo});
    span_ok = diff >= $signed(hsc_cmd_pkg::MIN_SPAN);
  endfunction

  // Classifies the command and checks its load value.
  always_comb begin
    verdict_out.accept   = 1'b1;
    verdict_out.err_code = hsc_cmd_pkg::ERR_NONE;
    if (code_in <= hsc_cmd_pkg::CMD_OTHER_LAST) begin
      verdict_out.accept = 1'b1;
    end else if (code_in >= hsc_cmd_pkg::CMD_LOAD_PRESET_LO &&
                 code_in <= hsc_cmd_pkg::CMD_LOAD_PRESET_HI) begin
      if (!in_limits(data_in, upper_in, lower_in)) begin
        verdict_out.accept   = 1'b0;
        verdict_out.err_code = hsc_cmd_pkg::ERR_LIMIT;
      end
    end else if (code_in == hsc_cmd_pkg::CMD_LOAD_ACCUM) begin
      if (!in_limits(data_in, upper_in, lower_in)) begin
        verdict_out.accept   = 1'b0;
        verdict_out.err_code = hsc_cmd_pkg::ERR_LIMIT;
      end
    end else if (code_in == hsc_cmd_pkg::CMD_LOAD_UPPER) begin
      if (!span_ok(data_in, lower_in)) begin
        verdict_out.accept   = 1'b0;
        verdict_out.err_code = hsc_cmd_pkg::ERR_SPAN;
      end
    end else if (code_in == hsc_cmd_pkg::CMD_LOAD_LOWER) begin
      if (!span_ok(upper_in, data_in)) begin
        verdict_out.accept   = 1'b0;
        verdict_out.err_code = hsc_cmd_pkg::ERR_SPAN;
      end
    end else if (code_in == hsc_cmd_pkg::CMD_LOAD_TIMEBASE) begin
      if (data_in < hsc_cmd_pkg::TIMEBASE_MIN ||
          data_in > hsc_cmd_pkg::TIMEBASE_MAX) begin
        verdict_out.accept   = 1'b0;
        verdict_out.err_code = hsc_cmd_pkg::ERR_TIMEBASE;
      end
    end else if (code_in == hsc_cmd_pkg::CMD_LOAD_SENSE) begin
      verdict_out.accept = 1'b1;
    end else if ((code_in >= hsc_cmd_pkg::CMD_RET_PRESET_LO &&
                  code_in <= hsc_cmd_pkg::CMD_RET_PRESET_HI) ||
                 (code_in >= hsc_cmd_pkg::CMD_RET_ACCUM &&
                  code_in <= hsc_cmd_pkg::CMD_RET_TIMEBASE)) begin
      verdict_out.accept = 1'b1;
    end else begin
      // Any reserved number is refused and nothing is stored.
      verdict_out.accept   = 1'b0;
      verdict_out.err_code = hsc_cmd_pkg::ERR_RESERVED;
    end
  end

endmodule
